// [cache_alloc_pkg.sv]
package cache_alloc_pkg;

  // ---------------------------------------------------------------
  // coprocessor encoding of the diagnostic control register
  // ---------------------------------------------------------------
  localparam logic [3:0] diag_crn     = 4'hf;
  localparam logic [2:0] diag_op1     = 3'h0;
  localparam logic [3:0] diag_crm     = 4'h0;
  localparam logic [2:0] diag_op2     = 3'h1;

  // ---------------------------------------------------------------
  // field positions and reset value
  // ---------------------------------------------------------------
  localparam int         dmb_as_dsb_bit      = 4;
  localparam int         no_direct_evict_bit = 21;
  localparam int         no_wa_wait_bit      = 22;
  localparam int         no_read_alloc_bit   = 23;
  localparam logic [31:0] diag_reset         = 32'h0000_0000;

  // ---------------------------------------------------------------
  // streaming detection
  // ---------------------------------------------------------------
  localparam logic [1:0] stream_trigger = 2'h2;

  // memory attribute of a write
  typedef enum logic [1:0] {
    attr_noncache   = 2'h0,
    attr_wthrough   = 2'h1,
    attr_wback      = 2'h2,
    attr_strong     = 2'h3
  } mem_attr_e;

  // coprocessor access
  typedef struct packed {
    logic       valid;
    logic       write;
    logic       secure;
    logic [3:0] crn;
    logic [2:0] op1;
    logic [3:0] crm;
    logic [2:0] op2;
    logic [31:0] wdata;
  } cp_req_s;

  // one cache write from the load/store unit
  typedef struct packed {
    logic      valid;
    logic      full_line;
    logic      shareable;
    mem_attr_e attr;
  } wr_req_s;

  // streaming states, gray coded
  typedef enum logic [1:0] {
    st_normal    = 2'b00,
    st_one_line  = 2'b01,
    st_streaming = 2'b11
  } stream_e;

endpackage : cache_alloc_pkg

// [write_classifier.sv]
`timescale 1ns/1ps
module write_classifier (
  input  wire logic                     cache_enable,
  input  wire logic                     asymmetric_core_mode,
  input  cache_alloc_pkg::wr_req_s      req,
  output logic                          uncacheable
);
  // ---------------------------------------------------------------
  // uncacheable classification
  // ---------------------------------------------------------------
  always_comb begin
    uncacheable = req.valid && (!cache_enable
                  || req.attr == cache_alloc_pkg::attr_noncache
                  || req.attr == cache_alloc_pkg::attr_wthrough
                  || (req.attr == cache_alloc_pkg::attr_wback && req.shareable
                      && asymmetric_core_mode));
  end
endmodule : write_classifier

// [cache_allocate_mode_control.sv]
`timescale 1ns/1ps
module cache_allocate_mode_control (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  cache_alloc_pkg::cp_req_s    cp_req,
  output logic                        cp_ack,
  output logic                        cp_undef,
  output logic [31:0]                 cp_rdata,
  input  wire logic                   cache_enable,
  input  wire logic                   asymmetric_core_mode,
  input  cache_alloc_pkg::wr_req_s    wr_req,
  output logic                        wr_uncacheable,
  output logic                        streaming_mode,
  output logic                        write_alloc_wait,
  output logic                        read_alloc_enable,
  output logic                        direct_evict_enable,
  output logic                        dmb_as_dsb
);

  // ---------------------------------------------------------------
  // internal state and decode nets
  // ---------------------------------------------------------------
  logic [31:0]              diag_q;
  logic [31:0]              diag_d;
  logic                     crn_match;
  logic                     op1_match;
  logic                     crm_match;
  logic                     op2_match;
  logic                     hit;
  logic                     diag_write;
  logic                     diag_read;
  logic                     ack_d;
  logic                     undef_d;
  logic [31:0]              rdata_d;
  logic                     unc;
  logic                     wr_cacheable;
  logic                     full_line_write;
  logic                     partial_write;
  logic                     no_direct_evict;
  logic                     no_wa_wait;
  logic                     no_read_alloc;
  logic                     barrier_full;
  logic                     stream_block;
  logic                     streaming_d;
  cache_alloc_pkg::stream_e st_q;
  cache_alloc_pkg::stream_e st_d;

  // ---------------------------------------------------------------
  // coprocessor decode
  // ---------------------------------------------------------------
  assign crn_match  = cp_req.crn == cache_alloc_pkg::diag_crn;
  assign op1_match  = cp_req.op1 == cache_alloc_pkg::diag_op1;
  assign crm_match  = cp_req.crm == cache_alloc_pkg::diag_crm;
  assign op2_match  = cp_req.op2 == cache_alloc_pkg::diag_op2;
  assign hit        = cp_req.valid && crn_match && op1_match && crm_match && op2_match;
  assign diag_write = hit && cp_req.write && cp_req.secure;
  assign diag_read  = hit && !cp_req.write;

  // ---------------------------------------------------------------
  // diagnostic register
  // ---------------------------------------------------------------
  for (genvar b = 0; b < 32; b++) begin : g_diag_bit
    assign diag_d[b] = diag_write ? cp_req.wdata[b] : diag_q[b];
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      diag_q <= cache_alloc_pkg::diag_reset;
    end else begin
      diag_q <= diag_d;
    end
  end

  // ---------------------------------------------------------------
  // control bits
  // ---------------------------------------------------------------
  assign no_direct_evict = diag_q[cache_alloc_pkg::no_direct_evict_bit];
  assign no_wa_wait      = diag_q[cache_alloc_pkg::no_wa_wait_bit];
  assign no_read_alloc   = diag_q[cache_alloc_pkg::no_read_alloc_bit];
  assign barrier_full    = diag_q[cache_alloc_pkg::dmb_as_dsb_bit];
  assign stream_block    = no_wa_wait || no_read_alloc;

  // ---------------------------------------------------------------
  // coprocessor answer
  // ---------------------------------------------------------------
  assign ack_d   = hit;
  assign undef_d = cp_req.valid && !hit;
  assign rdata_d = diag_read ? diag_q : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cp_ack <= 1'b0;
    end else begin
      cp_ack <= ack_d;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cp_undef <= 1'b0;
    end else begin
      cp_undef <= undef_d;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cp_rdata <= 32'h0000_0000;
    end else begin
      cp_rdata <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // write classification
  // ---------------------------------------------------------------
  write_classifier u_class (
    .cache_enable         (cache_enable),
    .asymmetric_core_mode (asymmetric_core_mode),
    .req                  (wr_req),
    .uncacheable          (unc)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_uncacheable <= 1'b0;
    end else begin
      wr_uncacheable <= unc;
    end
  end

  // ---------------------------------------------------------------
  // streaming next state
  // ---------------------------------------------------------------
  assign wr_cacheable    = wr_req.valid && !unc;
  assign full_line_write = wr_cacheable && wr_req.full_line;
  assign partial_write   = wr_cacheable && !wr_req.full_line;

  always_comb begin
    st_d = st_q;
    if (stream_block) begin
      st_d = cache_alloc_pkg::st_normal;
    end else begin
      case (st_q)
        cache_alloc_pkg::st_normal: begin
          if (full_line_write) begin
            st_d = cache_alloc_pkg::st_one_line;
          end
        end
        cache_alloc_pkg::st_one_line: begin
          if (full_line_write) begin
            st_d = cache_alloc_pkg::st_streaming;
          end else if (partial_write) begin
            st_d = cache_alloc_pkg::st_normal;
          end
        end
        cache_alloc_pkg::st_streaming: begin
          if (partial_write) begin
            st_d = cache_alloc_pkg::st_normal;
          end
        end
        default: begin
          st_d = cache_alloc_pkg::st_normal;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // streaming state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= cache_alloc_pkg::st_normal;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // mode outputs
  // ---------------------------------------------------------------
  assign streaming_d = (st_q == cache_alloc_pkg::st_streaming) && !stream_block;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      streaming_mode <= 1'b0;
    end else begin
      streaming_mode <= streaming_d;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      write_alloc_wait <= 1'b0;
    end else begin
      write_alloc_wait <= !no_wa_wait;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      read_alloc_enable <= 1'b0;
    end else begin
      read_alloc_enable <= !no_read_alloc;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      direct_evict_enable <= 1'b0;
    end else begin
      direct_evict_enable <= !no_direct_evict;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dmb_as_dsb <= 1'b0;
    end else begin
      dmb_as_dsb <= barrier_full;
    end
  end

endmodule : cache_allocate_mode_control

// [cache_alloc_chk.sv]
`timescale 1ns/1ps
module cache_alloc_chk (
  input wire logic                clk,
  input wire logic                sys_rst,
  input wire logic                cache_enable,
  input wire logic                asymmetric_core_mode,
  input wire logic                cp_ack,
  input wire logic                cp_undef,
  input wire logic                wr_uncacheable,
  input wire logic                streaming_mode,
  input wire logic                write_alloc_wait,
  input wire logic                read_alloc_enable,
  input wire logic                direct_evict_enable,
  input wire logic                dmb_as_dsb,
  input wire logic [31:0]         cp_rdata,
  input cache_alloc_pkg::cp_req_s cp_req,
  input cache_alloc_pkg::wr_req_s wr_req
);
  // ---
  // mode properties
  // ---
  wire unc = wr_req.valid && (!cache_enable
    || wr_req.attr == cache_alloc_pkg::attr_noncache
    || wr_req.attr == cache_alloc_pkg::attr_wthrough
    || wr_req.attr == cache_alloc_pkg::attr_wback && wr_req.shareable && asymmetric_core_mode);
  wire fl = wr_req.valid && wr_req.full_line && !unc;
  wire hit = cp_req.crn == cache_alloc_pkg::diag_crn
    && cp_req.op1 == cache_alloc_pkg::diag_op1
    && cp_req.crm == cache_alloc_pkg::diag_crm
    && cp_req.op2 == cache_alloc_pkg::diag_op2;
  wire wok = cp_req.valid && cp_req.write && cp_req.secure && hit;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_UNC: assert property (1'b1 |=> wr_uncacheable == $past(unc))
    else $error("write class wrong");
  AST_STREAM: assert property (fl ##1 fl ##1 (!wr_req.valid && write_alloc_wait
    && read_alloc_enable) [*2] |-> ##[0:1] streaming_mode) else $error("no streaming");
  AST_NOSTR: assert property (!write_alloc_wait [*2] |-> !streaming_mode)
    else $error("streaming while blocked");
  AST_EVICT: assert property (wok |-> ##2
    direct_evict_enable == !$past(cp_req.wdata[21], 2)) else $error("evict mode wrong");
  AST_WAWAIT: assert property (wok |-> ##2
    write_alloc_wait == !$past(cp_req.wdata[22], 2)) else $error("wait mode wrong");
  AST_RALLOC: assert property (wok |-> ##2
    read_alloc_enable == !$past(cp_req.wdata[23], 2)) else $error("read-allocate mode wrong");
  AST_NORA: assert property (!read_alloc_enable [*2] |-> !streaming_mode)
    else $error("streaming while read-allocate off");
  AST_DMB: assert property (wok |-> ##2
    dmb_as_dsb == $past(cp_req.wdata[4], 2)) else $error("barrier mode wrong");
  AST_NSEC: assert property (cp_req.valid && cp_req.write && !cp_req.secure
    && !$past(cp_req.valid) |-> ##2 $stable(write_alloc_wait) && $stable(dmb_as_dsb))
    else $error("non-secure write took effect");
  AST_ACK: assert property (cp_req.valid |=> cp_ack == $past(hit) && cp_undef != $past(hit))
    else $error("answer wrong");
  cover property (fl ##1 fl);
  cover property (cp_req.valid && !hit);
  cover property (cp_req.valid && cp_req.write && !cp_req.secure);
  cover property ($rose(streaming_mode));
endmodule : cache_alloc_chk
bind cache_allocate_mode_control cache_alloc_chk i_cache_alloc_chk (.*);

// [write_source.sv]
`timescale 1ns/1ps
module write_source (
  input  wire logic                clk,
  input  wire logic [1:0]          kind,
  input  wire logic [31:0]         rnd,
  output cache_alloc_pkg::wr_req_s wr_req
);
  // ---
  // load/store write traffic: idle, full write-back lines, random
  // ---
  always @(negedge clk) begin
    case (kind)
      2'h1: wr_req <= cache_alloc_pkg::wr_req_s'(5'h1a);
      2'h2: wr_req <= cache_alloc_pkg::wr_req_s'({1'b1, rnd[3:0]});
      default: wr_req <= cache_alloc_pkg::wr_req_s'({1'b0, rnd[3:0]});
    endcase
  end
endmodule : write_source

// [cache_allocate_mode_control_tb.sv]
`timescale 1ns/1ps
module cache_allocate_mode_control_tb;
  logic clk = 0, sys_rst = 1, cache_enable = 1, asymmetric_core_mode = 0, cp_ack, cp_undef;
  logic wr_uncacheable, streaming_mode, write_alloc_wait, read_alloc_enable;
  logic direct_evict_enable, dmb_as_dsb;
  logic [31:0] cp_rdata, rnd = 32'h18d460ce, v = 32'h0;
  logic [1:0] kind = 2'h0;
  logic [32:0] q[$];
  cache_alloc_pkg::cp_req_s cp_req = '0;
  cache_alloc_pkg::wr_req_s wr_req;
  int err_count = 0, check_count = 0, cyc = 0, bits[4] = '{4, 21, 22, 23};
  // ---
  // harness
  // ---
  always #50 clk = ~clk;
  cache_allocate_mode_control i_cache_allocate_mode_control (.*);
  write_source i_write_source (.*);
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction : xs
  task automatic chk(input logic [32:0] got, exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cp(input logic w, s, logic [3:0] crn, logic [31:0] d, logic [32:0] e);
    cp_req <= '{1'b1, w, s, crn, cache_alloc_pkg::diag_op1, cache_alloc_pkg::diag_crm,
      cache_alloc_pkg::diag_op2, d};
    q.push_back(e);
    @(negedge clk);
    cp_req.valid <= 1'b0;
    @(negedge clk);
  endtask : cp
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up
  always @(negedge clk) if (cp_ack || cp_undef) begin
    chk({cp_undef, cp_rdata}, q.size() ? q.pop_front() : 33'h1ffffffff);
  end
  always @(posedge clk) if (++cyc == 3000) begin
    err_count++;
    wrap_up();
  end
  initial begin
    repeat (20) @(negedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(negedge clk);
    chk({write_alloc_wait, read_alloc_enable, direct_evict_enable, dmb_as_dsb}, 33'he);
    cp(0, 1, 4'hf, 0, 33'h0);
    foreach (bits[i]) begin
      v |= 32'h1 << bits[i];
      cp(1, 1, 4'hf, v, 33'h0);
      cp(0, 1, 4'hf, 0, {1'b0, v});
      chk({direct_evict_enable, write_alloc_wait, read_alloc_enable, dmb_as_dsb},
        {!v[21], !v[22], !v[23], v[4]});
    end
    cp(1, 0, 4'hf, 0, 33'h0);
    cp(0, 1, 4'hf, 0, {1'b0, v});
    cp(0, 1, 4'h0, 0, 33'h100000000);
    $display("register test done");
    cp(1, 1, 4'hf, 0, 33'h0);
    kind <= 2'h1;
    repeat (cache_alloc_pkg::stream_trigger) @(negedge clk);
    kind <= 2'h0;
    repeat (3) @(negedge clk);
    chk(streaming_mode, 1);
    cp(1, 1, 4'hf, 32'h00400000, 33'h0);
    @(negedge clk);
    chk(streaming_mode, 0);
    kind <= 2'h1;
    repeat (4) @(negedge clk);
    kind <= 2'h0;
    repeat (3) @(negedge clk);
    chk(streaming_mode, 0);
    cp(1, 1, 4'hf, 32'h00800000, 33'h0);
    kind <= 2'h1;
    repeat (4) @(negedge clk);
    kind <= 2'h0;
    repeat (3) @(negedge clk);
    chk(streaming_mode, 0);
    $display("streaming test done");
    kind <= 2'h2;
    repeat (60) begin
      @(negedge clk);
      chk(wr_uncacheable, wr_req.valid && (!cache_enable
        || wr_req.attr == cache_alloc_pkg::attr_noncache
        || wr_req.attr == cache_alloc_pkg::attr_wthrough
        || wr_req.attr == cache_alloc_pkg::attr_wback && wr_req.shareable
        && asymmetric_core_mode));
      rnd <= xs(rnd);
      cache_enable <= rnd[4];
      asymmetric_core_mode <= rnd[5];
    end
    kind <= 2'h0;
    repeat (2) @(negedge clk);
    $display("classify test done");
    chk(q.size(), 0);
    wrap_up();
  end
endmodule : cache_allocate_mode_control_tb
